//--- pkg/mfl_consts.svh
/*
 Constants for the move-or-load execution unit: encodings, access-bank split,
 software port indices and reset values. Assumes inclusion by bare name.
*/
`ifndef MFL_CONSTS_SVH
`define MFL_CONSTS_SVH

// Opcode fields
`define MFL_OPC_IOR       6'h04
`define MFL_OPC_MOVE      6'h14
`define MFL_OPC_PTR       10'h3b8
`define MFL_OPC_PTR_W2    8'hf0
`define MFL_OPC_F2F       4'hc
`define MFL_OPC_F2F_W2    4'hf
`define MFL_OPC_BANK      8'h01
`define MFL_FSR_COUNT     2'h3

// Access bank split and indexed window limit
`define MFL_ACC_LIMIT     8'h5f
`define MFL_ACC_HI_BANK   4'hf

// Data-space alias of the working register
`define MFL_W_ALIAS       12'hfe0

// Software port register indices
`define MFL_RB_CTRL       4'h0
`define MFL_RB_WREG       4'h1
`define MFL_RB_BANK       4'h2
`define MFL_RB_STATUS     4'h3
`define MFL_RB_PTR0_LO    4'h4
`define MFL_RB_PTR_LAST   4'h9

// Field positions
`define MFL_CTRL_EXT_BIT  0
`define MFL_STAT_Z_BIT    0
`define MFL_STAT_N_BIT    1

// Reset values
`define MFL_RST_W         8'h00
`define MFL_RST_BANK      4'h0
`define MFL_RST_EXT       1'b0

`endif

//--- pkg/mfl_pkg.sv
/*
 Types for the move-or-load execution unit.
 Assumes the constants header sits beside it.
*/
package mfl_pkg;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mfl_phase_t;

  typedef enum logic [2:0] {OP_NONE, OP_IOR, OP_MOVE, OP_PTR, OP_F2F,
                            OP_BANK} mfl_op_t;

  typedef struct packed {
    logic        vld;
    logic [15:0] word;
  } mfl_instr_t;

  typedef struct packed {
    logic        rd;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mfl_dm_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } mfl_rb_t;

  typedef struct packed {
    logic [7:0] w;
    logic [7:0] bank;
    logic       n;
    logic       z;
  } mfl_view_t;

  typedef struct packed {
    mfl_phase_t phase;
  } mfl_phase_st_t;

  typedef struct packed {
    logic [7:0]        w;
    logic [3:0]        bank_sel;
    logic              n;
    logic              z;
    logic              ext_en;
    logic [2:0][11:0]  fsr;
    mfl_op_t           op;
    logic              second;
    logic              got2;
    logic              dst_f;
    logic [1:0]        sel;
    logic [7:0]        res;
    logic [11:0]       dest;
    mfl_dm_t           dm;
    logic [7:0]        rdata;
  } mfl_core_st_t;

endpackage

//--- rtl/mfl_phase.sv
/*
 Four-phase sequencer: one phase per clock, Q1 to Q4 and round again.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module mfl_phase (
  input  wire logic               clk,
  input  wire logic               rst_b,
  output mfl_pkg::mfl_phase_t     phase_o
);
  import mfl_pkg::*;

  mfl_phase_st_t q;
  mfl_phase_st_t d;

  always_comb begin
    d = q;
    case (q.phase)
      PH_Q1:   d.phase = PH_Q2;
      PH_Q2:   d.phase = PH_Q3;
      PH_Q3:   d.phase = PH_Q4;
      default: d.phase = PH_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{phase: PH_Q1};
    end else begin
      q <= d;
    end
  end

  assign phase_o = q.phase;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_rest_of_cycle;
    phase_o == PH_Q2 ##1 phase_o == PH_Q3 ##1 phase_o == PH_Q4 ##1 phase_o == PH_Q1;
  endsequence

  a_four_phase_cycle: assert property (phase_o == PH_Q1 |=> s_rest_of_cycle)
    else $error("Instruction cycle is not four phases");

endmodule // mfl_phase

//--- rtl/mfl_addr_res.sv
/*
 Resolves the 8-bit file field of a byte operation to a 12-bit data address.
 Assumes bank register and pointer 2 come from registered state.
*/
`timescale 1ns/100ps
`include "mfl_consts.svh"
module mfl_addr_res (
  input  wire logic [7:0]  f_i,
  input  wire logic        a_i,
  input  wire logic [3:0]  bank_i,
  input  wire logic        ext_en_i,
  input  wire logic [11:0] ptr2_i,
  output logic      [11:0] addr_o
);
  import mfl_pkg::*;

  always_comb begin
    if (a_i) begin
      addr_o = {bank_i, f_i};
    end else if (ext_en_i && (f_i <= `MFL_ACC_LIMIT)) begin
      addr_o = ptr2_i + {4'h0, f_i};
    end else if (f_i <= `MFL_ACC_LIMIT) begin
      addr_o = {4'h0, f_i};
    end else begin
      addr_o = {`MFL_ACC_HI_BANK, f_i};
    end
  end

endmodule // mfl_addr_res

//--- rtl/mfl_core.sv
/*
 Execution unit for OR-with-file, move-file, file-to-file move, pointer load
 and bank load, with working register, bank, flags and three pointers.
 Assumes a data memory answering a read in the clock after its strobe, and an
 instruction word presented while the sequencer sits in Q1.
*/
// Notes on behaviour
// - Opcode 000100 ORs working register with file register; N and Z follow result.
// - OR result goes to working register when d is 0, file when 1.
// - a equal 0 picks the access bank; a equal 1 uses bank register.
// - Extended mode with a 0 and f up to 5Fh indexes from pointer 2.
// - The 8-bit file field reaches any byte of the selected bank.
// - Opcode 010100 copies the file register; N and Z follow the value.
// - Move-file result to working register when d is 0, file when 1.
// - Pointer load: high part in first cycle, low byte in second cycle.
// - File-to-file move reads source in first cycle, writes destination in second.
// - File-to-file move may use working register either side; flags untouched.
// - Bank load writes low nibble; upper four bank bits read zero.
`timescale 1ns/100ps
`include "mfl_consts.svh"
module mfl_core (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire mfl_pkg::mfl_instr_t instr_i,
  input  wire logic [7:0]          dm_rdata_i,
  output mfl_pkg::mfl_dm_t         dm_o,
  input  wire mfl_pkg::mfl_rb_t    rb_i,
  output logic [7:0]               rb_rdata_o,
  output mfl_pkg::mfl_view_t       view_o,
  output mfl_pkg::mfl_phase_t      phase_o
);
  import mfl_pkg::*;

  mfl_core_st_t q;
  mfl_core_st_t d;
  mfl_phase_t   phase;
  mfl_phase_t   phase_q;
  logic [11:0]  rs_addr;
  logic [15:0]  word;

  assign word = instr_i.word;

  mfl_phase u_phase (
    .clk     (clk),
    .rst_b   (rst_b),
    .phase_o (phase)
  );

  mfl_addr_res u_res (
    .f_i      (word[7:0]),
    .a_i      (word[8]),
    .bank_i   (q.bank_sel),
    .ext_en_i (q.ext_en),
    .ptr2_i   (q.fsr[2]),
    .addr_o   (rs_addr)
  );

  always_comb begin
    logic [7:0] src;
    logic [7:0] res;
    logic [3:0] ridx;
    src  = (q.dest == `MFL_W_ALIAS) ? q.w : dm_rdata_i;
    res  = q.res;
    ridx = 4'h0;
    d          = q;
    d.dm.rd    = 1'b0;
    d.dm.we    = 1'b0;
    d.rdata    = 8'h00;
    case (phase)
      PH_Q1: begin
        if (instr_i.vld && q.second) begin
          if (q.op == OP_PTR && word[15:8] == `MFL_OPC_PTR_W2) begin
            d.res  = word[7:0];
            d.got2 = 1'b1;
          end else if (q.op == OP_F2F && word[15:12] == `MFL_OPC_F2F_W2) begin
            d.dest = word[11:0];
            d.got2 = 1'b1;
          end else begin
            d.op     = OP_NONE;
            d.second = 1'b0;
          end
        end else if (instr_i.vld) begin
          d.dst_f = word[9];
          if (word[15:10] == `MFL_OPC_IOR || word[15:10] == `MFL_OPC_MOVE) begin
            d.op      = (word[15:10] == `MFL_OPC_IOR) ? OP_IOR : OP_MOVE;
            d.dest    = rs_addr;
            d.dm.addr = rs_addr;
            d.dm.rd   = (rs_addr != `MFL_W_ALIAS);
          end else if (word[15:6] == `MFL_OPC_PTR && word[5:4] != `MFL_FSR_COUNT) begin
            d.op  = OP_PTR;
            d.sel = word[5:4];
            d.res = {4'h0, word[3:0]};
          end else if (word[15:12] == `MFL_OPC_F2F) begin
            d.op      = OP_F2F;
            d.dest    = word[11:0];
            d.dm.addr = word[11:0];
            d.dm.rd   = (word[11:0] != `MFL_W_ALIAS);
          end else if (word[15:8] == `MFL_OPC_BANK) begin
            d.op  = OP_BANK;
            d.res = word[7:0];
          end else begin
            d.op = OP_NONE;
          end
        end else if (!q.second) begin
          // No word and no two-word op pending: unit goes idle
          d.op = OP_NONE;
        end
      end
      PH_Q2: begin
        d.op = q.op;
      end
      PH_Q3: begin
        if (!q.second && (q.op == OP_IOR || q.op == OP_MOVE || q.op == OP_F2F)) begin
          res   = (q.op == OP_IOR) ? (q.w | src) : src;
          d.res = res;
          if (q.op != OP_F2F && q.dst_f && q.dest != `MFL_W_ALIAS) begin
            d.dm.we    = 1'b1;
            d.dm.addr  = q.dest;
            d.dm.wdata = res;
          end
        end else if (q.second && q.got2 && q.op == OP_F2F && q.dest != `MFL_W_ALIAS) begin
          d.dm.we    = 1'b1;
          d.dm.addr  = q.dest;
          d.dm.wdata = q.res;
        end
      end
      default: begin
        case (q.op)
          OP_IOR, OP_MOVE: begin
            if (!q.dst_f || q.dest == `MFL_W_ALIAS) begin
              d.w = q.res;
            end
            d.n  = q.res[7];
            d.z  = (q.res == 8'h00);
            d.op = OP_NONE;
          end
          OP_PTR: begin
            if (q.second && q.got2) begin
              d.fsr[q.sel][7:0] = q.res;
              d.second          = 1'b0;
              d.got2            = 1'b0;
              d.op              = OP_NONE;
            end else if (!q.second) begin
              d.fsr[q.sel][11:8] = q.res[3:0];
              d.second           = 1'b1;
            end
          end
          OP_F2F: begin
            if (q.second && q.got2) begin
              if (q.dest == `MFL_W_ALIAS) begin
                d.w = q.res;
              end
              d.second = 1'b0;
              d.got2   = 1'b0;
              d.op     = OP_NONE;
            end else if (!q.second) begin
              d.second = 1'b1;
            end
          end
          OP_BANK: begin
            d.bank_sel = q.res[3:0];
            d.op  = OP_NONE;
          end
          default: begin
            d.op = OP_NONE;
          end
        endcase
      end
    endcase
    // Software port; a software write lands after the instruction's own update
    if (rb_i.wr) begin
      if (rb_i.addr == `MFL_RB_CTRL) begin
        d.ext_en = rb_i.wdata[`MFL_CTRL_EXT_BIT];
      end else if (rb_i.addr == `MFL_RB_WREG) begin
        d.w = rb_i.wdata;
      end else if (rb_i.addr == `MFL_RB_BANK) begin
        d.bank_sel = rb_i.wdata[3:0];
      end
    end
    if (rb_i.rd) begin
      ridx = rb_i.addr - `MFL_RB_PTR0_LO;
      if (rb_i.addr == `MFL_RB_CTRL) begin
        d.rdata = {7'h00, q.ext_en};
      end else if (rb_i.addr == `MFL_RB_WREG) begin
        d.rdata = q.w;
      end else if (rb_i.addr == `MFL_RB_BANK) begin
        d.rdata = {4'h0, q.bank_sel};
      end else if (rb_i.addr == `MFL_RB_STATUS) begin
        d.rdata = {6'h00, q.n, q.z};
      end else if (rb_i.addr >= `MFL_RB_PTR0_LO && rb_i.addr <= `MFL_RB_PTR_LAST) begin
        d.rdata = ridx[0] ? {4'h0, q.fsr[ridx[2:1]][11:8]} : q.fsr[ridx[2:1]][7:0];
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{w: `MFL_RST_W, bank_sel: `MFL_RST_BANK, n: 1'b0, z: 1'b0,
             ext_en: `MFL_RST_EXT, fsr: '0, op: OP_NONE, second: 1'b0, got2: 1'b0,
             dst_f: 1'b0, sel: 2'h0, res: 8'h00, dest: 12'h000,
             dm: '0, rdata: 8'h00};
      phase_q <= PH_Q1;
    end else begin
      q       <= d;
      phase_q <= phase;
    end
  end

  assign dm_o       = q.dm;
  assign rb_rdata_o = q.rdata;
  assign view_o     = '{w: q.w, bank: {4'h0, q.bank_sel}, n: q.n, z: q.z};
  assign phase_o    = phase_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic q1_byte;
  assign q1_byte = phase == PH_Q1 && instr_i.vld && !q.second &&
                   (word[15:10] == `MFL_OPC_IOR || word[15:10] == `MFL_OPC_MOVE);

  sequence s_ptr_first;
    phase == PH_Q4 && q.op == OP_PTR && !q.second;
  endsequence

  sequence s_ptr_second;
    phase == PH_Q4 && q.op == OP_PTR && q.second && q.got2;
  endsequence

  a_ior_work_result: assert property (
    phase == PH_Q4 && q.op == OP_IOR && !q.dst_f && q.dest != `MFL_W_ALIAS
    |=> q.w == $past(q.res) && q.z == (q.w == 8'h00) && q.n == q.w[7])
    else $error("OR result or flags wrong in working register");

  a_ior_file_write: assert property (
    phase == PH_Q3 && q.op == OP_IOR && q.dst_f && q.dest != `MFL_W_ALIAS
    |=> dm_o.we && dm_o.addr == $past(q.dest) && $stable(q.w))
    else $error("OR result not written back to file");

  a_bank_select_addr: assert property (
    q1_byte && word[8] && rs_addr != `MFL_W_ALIAS
    |=> dm_o.rd && dm_o.addr[11:8] == $past(q.bank_sel))
    else $error("Banked address not taken from bank register");

  a_indexed_offset: assert property (
    q1_byte && !word[8] && q.ext_en && word[7:0] <= `MFL_ACC_LIMIT
    |=> q.dest == $past(q.fsr[2]) + {4'h0, $past(word[7:0])})
    else $error("Indexed offset address wrong");

  a_bank_reach: assert property (
    q1_byte && word[8] |=> q.dest[7:0] == $past(word[7:0]))
    else $error("File field not reaching bank byte");

  a_move_copy: assert property (
    phase == PH_Q3 && q.op == OP_MOVE && q.dest != `MFL_W_ALIAS
    |=> q.res == $past(dm_rdata_i) ##1 q.z == (q.res == 8'h00))
    else $error("Move-file value or zero flag wrong");

  a_move_dest: assert property (
    phase == PH_Q4 && q.op == OP_MOVE && q.dst_f && q.dest != `MFL_W_ALIAS
    |=> $stable(q.w))
    else $error("Move-file with d set changed working register");

  a_ptr_high_first: assert property (
    s_ptr_first |=> q.fsr[$past(q.sel)][11:8] == $past(q.res[3:0]) && q.second)
    else $error("Pointer load high part wrong in first cycle");

  a_ptr_low_second: assert property (
    s_ptr_second |=> q.fsr[$past(q.sel)][7:0] == $past(q.res) && !q.second)
    else $error("Pointer load low byte wrong in second cycle");

  a_f2f_no_read: assert property (
    phase == PH_Q1 && q.second && q.op == OP_F2F |=> !dm_o.rd [*4])
    else $error("File-to-file move read in its second cycle");

  a_f2f_flags: assert property (
    q.op == OP_F2F |=> $stable(q.n) && $stable(q.z))
    else $error("File-to-file move changed flags");

  a_bank_upper_zero: assert property (
    phase == PH_Q4 && q.op == OP_BANK && !rb_i.wr
    |=> view_o.bank == {4'h0, $past(q.res[3:0])})
    else $error("Bank load wrong or upper bits set");

  a_single_cycle: assert property (
    q1_byte |=> dm_o.rd || q.dest == `MFL_W_ALIAS ##3 q.op == OP_NONE)
    else $error("Single-word operation did not end in one cycle");

endmodule // mfl_core

//--- dv/mfl_tb.sv
/*
 Self-checking bench for the move-or-load execution unit: drives the
 instruction port, the software port and a behavioural data memory.
 Assumes the package and the constants header are compiled ahead of it.
*/
`timescale 1ns/100ps
`include "mfl_consts.svh"
module tb;
  import mfl_pkg::*;
  logic        clk;
  logic        rst_b;
  mfl_instr_t  instr;
  logic [7:0]  dm_rdata;
  mfl_dm_t     dm;
  mfl_rb_t     rb;
  logic [7:0]  rb_rdata;
  mfl_view_t   view;
  mfl_phase_t  phase;
  logic [7:0]  mem [0:4095];
  int          mismatches;
  int          n_compared;
  int          cyc;
  int          n_rd;
  int          n_we;
  int          rd_cyc;
  int          we_cyc;
  int          c0;
  logic [11:0] rd_addr;
  logic [11:0] we_addr;
  logic [7:0]  we_data;

  mfl_core dut (.clk(clk), .rst_b(rst_b), .instr_i(instr), .dm_rdata_i(dm_rdata),
    .dm_o(dm), .rb_i(rb), .rb_rdata_o(rb_rdata), .view_o(view), .phase_o(phase));

  always #10 clk = ~clk;

  // Data memory; junk on the read bus outside a read answer
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dm.rd) begin
      dm_rdata <= mem[dm.addr];
      n_rd <= n_rd + 1;
      rd_cyc <= cyc;
      rd_addr <= dm.addr;
    end else begin
      dm_rdata <= ~dm_rdata;
    end
    if (dm.we) begin
      mem[dm.addr] <= dm.wdata;
      n_we <= n_we + 1;
      we_cyc <= cyc;
      we_addr <= dm.addr;
      we_data <= dm.wdata;
    end
    if (cyc > 3000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Presents a word during the next decode clock
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (phase !== PH_Q4 && n < 8);
    instr <= '{vld: 1'b1, word: w};
    @(posedge clk);
    instr.vld <= 1'b0;
    #1;
    c0 = cyc - 1;
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic rb_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    rb <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    rb.wr <= 1'b0;
  endtask

  task automatic rb_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rb <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    rb.rd <= 1'b0;
    #1;
    d = rb_rdata;
  endtask

  task automatic t_reset();
    logic [7:0] v;
    chk({view.w, view.bank[3:0]}, 12'h000, "w and bank after reset");
    rb_rd(`MFL_RB_CTRL, v);
    chk({4'h0, v}, 12'h000, "control after reset");
    rb_rd(4'hf, v);
    chk({4'h0, v}, 12'h000, "unmapped read");
    rb_wr(`MFL_RB_STATUS, 8'h03);
    rb_rd(`MFL_RB_STATUS, v);
    chk({4'h0, v}, 12'h000, "status is read-only");
    $display("test reset done");
  endtask

  task automatic t_or();
    int w0;
    rb_wr(`MFL_RB_BANK, 8'h02);
    rb_wr(`MFL_RB_WREG, 8'h13);
    mem[12'h234] = 8'h91;
    w0 = n_we;
    issue({`MFL_OPC_IOR, 1'b0, 1'b1, 8'h34});
    settle();
    chk({4'h0, view.w}, 12'h093, "or into w");
    chk({10'h0, view.n, view.z}, 12'h002, "or flags negative");
    chk(rd_addr, 12'h234, "banked read address");
    chk(12'(n_we - w0), 12'h000, "no file write when d is 0");
    mem[12'h2ff] = 8'h40;
    issue({`MFL_OPC_IOR, 1'b1, 1'b1, 8'hff});
    settle();
    chk(we_addr, 12'h2ff, "top of bank written");
    chk({4'h0, we_data}, 12'h0d3, "or into file");
    chk({4'h0, view.w}, 12'h093, "w kept when d is 1");
    chk(12'(rd_cyc - c0), 12'h001, "read in second phase");
    chk(12'(we_cyc - c0), 12'h003, "write in fourth phase");
    rb_wr(`MFL_RB_WREG, 8'h00);
    mem[12'h200] = 8'h00;
    issue({`MFL_OPC_IOR, 1'b0, 1'b1, 8'h00});
    settle();
    chk({10'h0, view.n, view.z}, 12'h001, "or flags zero");
    $display("test or done");
  endtask

  task automatic t_access();
    logic [22:0] tab [6];
    tab = '{{1'b0, 1'b0, 1'b0, 8'h10, 12'h010}, {1'b0, 1'b0, 1'b0, 8'h80, 12'hf80},
            {1'b0, 1'b1, 1'b0, 8'h5f, 12'h3ab + 12'h05f}, {1'b0, 1'b1, 1'b0, 8'h60, 12'hf60},
            {1'b0, 1'b1, 1'b1, 8'h05, 12'h205}, {1'b0, 1'b1, 1'b0, 8'h00, 12'h3ab}};
    issue({`MFL_OPC_PTR, 2'h2, 4'h3});
    issue({`MFL_OPC_PTR_W2, 8'hab});
    settle();
    for (int i = 0; i < 6; i++) begin
      rb_wr(`MFL_RB_CTRL, {7'h00, tab[i][21]});
      issue({`MFL_OPC_MOVE, 1'b0, tab[i][20], tab[i][19:12]});
      settle();
      chk(rd_addr, tab[i][11:0], "resolved file address");
    end
    rb_wr(`MFL_RB_CTRL, 8'h00);
    $display("test access done");
  endtask

  task automatic t_move();
    mem[12'h2a0] = 8'h00;
    mem[12'h2a1] = 8'h85;
    rb_wr(`MFL_RB_WREG, 8'h77);
    issue({`MFL_OPC_MOVE, 1'b0, 1'b1, 8'ha0});
    settle();
    chk({4'h0, view.w}, 12'h000, "move to w");
    chk({10'h0, view.n, view.z}, 12'h001, "move flags zero");
    issue({`MFL_OPC_MOVE, 1'b1, 1'b1, 8'ha1});
    settle();
    chk(we_addr, 12'h2a1, "written back in place");
    chk({4'h0, we_data}, 12'h085, "value written back");
    chk({4'h0, view.w}, 12'h000, "w kept");
    chk({10'h0, view.n, view.z}, 12'h002, "move flags negative");
    $display("test move file done");
  endtask

  task automatic t_pointer();
    logic [7:0]  v;
    logic [7:0]  lo;
    logic [11:0] k;
    for (int s = 0; s < 3; s++) begin
      k = 12'hc5a + 12'(s * 12'h111);
      rb_rd(4'(`MFL_RB_PTR0_LO + 2 * s), lo);
      issue({`MFL_OPC_PTR, 2'(s), k[11:8]});
      settle();
      rb_rd(4'(`MFL_RB_PTR0_LO + 2 * s + 1), v);
      chk({4'h0, v}, {8'h00, k[11:8]}, "pointer high after first cycle");
      rb_rd(4'(`MFL_RB_PTR0_LO + 2 * s), v);
      chk({4'h0, v}, {4'h0, lo}, "pointer low untouched yet");
      issue({`MFL_OPC_PTR_W2, k[7:0]});
      settle();
      rb_rd(4'(`MFL_RB_PTR0_LO + 2 * s), v);
      chk({4'h0, v}, {4'h0, k[7:0]}, "pointer low after second cycle");
    end
    $display("test pointer load done");
  endtask

  task automatic t_file_to_file();
    int r0;
    int w0;
    mem[12'h123] = 8'h33;
    r0 = n_rd;
    issue({`MFL_OPC_F2F, 12'h123});
    issue({`MFL_OPC_F2F_W2, 12'h456});
    settle();
    chk(we_addr, 12'h456, "far destination");
    chk({4'h0, we_data}, 12'h033, "far data");
    chk(12'(n_rd - r0), 12'h001, "single read");
    chk(12'(we_cyc - c0), 12'h003, "write in second cycle");
    chk({10'h0, view.n, view.z}, 12'h002, "flags kept");
    w0 = n_we;
    issue({`MFL_OPC_F2F, 12'h123});
    issue({`MFL_OPC_F2F_W2, `MFL_W_ALIAS});
    settle();
    chk({4'h0, view.w}, 12'h033, "w as destination");
    chk(12'(n_we - w0), 12'h000, "no memory write for w");
    issue({`MFL_OPC_F2F, `MFL_W_ALIAS});
    issue({`MFL_OPC_F2F_W2, 12'h050});
    settle();
    chk({4'h0, mem[12'h050]}, 12'h033, "w as source");
    $display("test file to file done");
  endtask

  task automatic t_bank();
    logic [7:0] v;
    issue({`MFL_OPC_BANK, 8'hf5});
    settle();
    chk({4'h0, view.bank}, 12'h005, "bank view upper zero");
    rb_rd(`MFL_RB_BANK, v);
    chk({4'h0, v}, 12'h005, "bank read upper zero");
    $display("test bank load done");
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    instr = '0;
    rb = '0;
    dm_rdata = 8'h00;
    cyc = 0;
    mismatches = 0;
    n_compared = 0;
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'ha5;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_or();
    t_access();
    t_move();
    t_pointer();
    t_file_to_file();
    t_bank();
    give_verdict();
  end
endmodule // tb
